//--- hw/umcs_pkg.sv
package umcs_pkg;
    // register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register byte addresses
    localparam logic [7:0] MCR_OFS = 8'h00;
    localparam logic [7:0] MSR_OFS = 8'h04;
    localparam logic [7:0] EFR_OFS = 8'h08;
    localparam logic [7:0] IER_OFS = 8'h0c;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] FLOW_THR_OFS = 8'h18;
    localparam logic [7:0] TRIG_LVL_OFS = 8'h1c;

    // modem_control fields
    localparam int unsigned MCR_CLKSEL = 7;
    localparam int unsigned MCR_THR_EN = 6;
    localparam int unsigned MCR_XON_ANY = 5;
    localparam int unsigned MCR_LOOP = 4;
    localparam int unsigned MCR_IRQ_OP = 3;
    localparam int unsigned MCR_FRDY = 2;
    localparam int unsigned MCR_RTS = 1;
    localparam int unsigned MCR_DTR = 0;
    localparam logic [7:0] MCR_PROT = 8'he0;
    localparam logic [7:0] IER_PROT = 8'hf0;

    // other fields
    localparam int unsigned EFR_WEN = 4;
    localparam int unsigned IER_MODEM = 3;

    // modem_status delta field positions, low nibble
    localparam int unsigned D_CD = 3;
    localparam int unsigned D_RI = 2;
    localparam int unsigned D_DSR = 1;
    localparam int unsigned D_CTS = 0;

    // interrupt status and mask layout
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_MODEM = 0;
    localparam int unsigned IRQ_RING = 1;
    localparam int unsigned IRQ_DENIED = 2;

    // reset values
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] EFR_RST = 8'h00;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] FLOW_RST = 8'h00;
    localparam logic [7:0] TRIG_RST = 8'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h7;
    localparam logic [3:0] SRC_RST = 4'h0;

    // prescaler: terminal count of the divide-by-four counter
    localparam logic [1:0] PRESC_LAST = 2'h3;

    // synchronised pin indices
    localparam int unsigned N_IN = 5;
    localparam int unsigned IN_CTS = 0;
    localparam int unsigned IN_DSR = 1;
    localparam int unsigned IN_RI = 2;
    localparam int unsigned IN_CD = 3;
    localparam int unsigned IN_RX = 4;
    localparam logic [4:0] IN_IDLE = 5'h1f;
endpackage

//--- hw/umcs_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface umcs_sync_if;
    logic [umcs_pkg::N_IN-1:0] raw;
    logic [umcs_pkg::N_IN-1:0] synced;
    modport core (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

//--- hw/umcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module umcs_sync (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // pins in, synchronised levels out
    umcs_sync_if.sync sif
);
    logic [umcs_pkg::N_IN-1:0] s1_q;
    logic [umcs_pkg::N_IN-1:0] s1_d;
    logic [umcs_pkg::N_IN-1:0] s2_q;
    logic [umcs_pkg::N_IN-1:0] s2_d;

    // two stages per pin; idle pins are high
    for (genvar i = 0; i < umcs_pkg::N_IN; i++) begin : g_bit
        always_comb begin
            s1_d[i] = sif.raw[i];
            s2_d[i] = s1_q[i];
        end
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                s1_q[i] <= umcs_pkg::IN_IDLE[i];
                s2_q[i] <= umcs_pkg::IN_IDLE[i];
            end else begin
                s1_q[i] <= s1_d[i];
                s2_q[i] <= s2_d[i];
            end
        end
    end

    assign sif.synced = s2_q;
endmodule
`default_nettype wire

//--- hw/umcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module umcs_top (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [umcs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [umcs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [umcs_pkg::DATA_W-1:0] reg_rdata,
    // modem pins, active low
    input wire logic clear_send_in,
    input wire logic set_ready_in,
    input wire logic carrier_detect_in,
    input wire logic ring_indicator_in,
    output logic request_send_out,
    output logic terminal_ready_out,
    output logic general_out_pin,
    // interrupt pin with enable, enable low while driven
    output logic irq_out_chan_a,
    output logic irq_out_chan_a_oe_n,
    // serial pins and core serial data
    input wire logic serial_rx_in,
    output logic serial_tx_out,
    input wire logic core_tx_data,
    output logic core_rx_data,
    // flow control from the core
    input wire logic auto_rts_enable,
    input wire logic auto_rts_assert,
    // configuration towards the core
    output logic baud_tick,
    output logic threshold_access,
    output logic xon_any_enable,
    output logic fifo_ready_enable,
    output logic loopback_active,
    output logic [umcs_pkg::DATA_W-1:0] flow_threshold,
    output logic [umcs_pkg::DATA_W-1:0] trigger_level
);
    // synchroniser
    umcs_sync_if sif();

    assign sif.raw[umcs_pkg::IN_CTS] = clear_send_in;
    assign sif.raw[umcs_pkg::IN_DSR] = set_ready_in;
    assign sif.raw[umcs_pkg::IN_RI] = ring_indicator_in;
    assign sif.raw[umcs_pkg::IN_CD] = carrier_detect_in;
    assign sif.raw[umcs_pkg::IN_RX] = serial_rx_in;

    umcs_sync u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .sif(sif)
    );

    // address decode
    logic hit_mcr;
    logic hit_msr;
    logic hit_efr;
    logic hit_ier;
    logic hit_stat;
    logic hit_mask;
    logic hit_flow;
    logic hit_trig;

    always_comb begin
        hit_mcr = 1'b0;
        hit_msr = 1'b0;
        hit_efr = 1'b0;
        hit_ier = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        hit_flow = 1'b0;
        hit_trig = 1'b0;
        if (reg_addr == umcs_pkg::MCR_OFS) begin
            hit_mcr = 1'b1;
        end else if (reg_addr == umcs_pkg::MSR_OFS) begin
            hit_msr = 1'b1;
        end else if (reg_addr == umcs_pkg::EFR_OFS) begin
            hit_efr = 1'b1;
        end else if (reg_addr == umcs_pkg::IER_OFS) begin
            hit_ier = 1'b1;
        end else if (reg_addr == umcs_pkg::IRQ_STAT_OFS) begin
            hit_stat = 1'b1;
        end else if (reg_addr == umcs_pkg::IRQ_MASK_OFS) begin
            hit_mask = 1'b1;
        end else if (reg_addr == umcs_pkg::FLOW_THR_OFS) begin
            hit_flow = 1'b1;
        end else if (reg_addr == umcs_pkg::TRIG_LVL_OFS) begin
            hit_trig = 1'b1;
        end
    end

    // control registers
    logic [7:0] mcr_q;
    logic [7:0] mcr_d;
    logic [7:0] efr_q;
    logic [7:0] efr_d;
    logic [7:0] ier_q;
    logic [7:0] ier_d;
    logic [7:0] flow_q;
    logic [7:0] flow_d;
    logic [7:0] trig_q;
    logic [7:0] trig_d;
    logic [umcs_pkg::IRQ_W-1:0] mask_q;
    logic [umcs_pkg::IRQ_W-1:0] mask_d;
    logic wen;
    logic thr_open;
    logic denied;

    assign wen = efr_q[umcs_pkg::EFR_WEN];
    assign thr_open = mcr_q[umcs_pkg::MCR_THR_EN];

    always_comb begin
        mcr_d = mcr_q;
        efr_d = efr_q;
        ier_d = ier_q;
        flow_d = flow_q;
        trig_d = trig_q;
        mask_d = mask_q;
        denied = 1'b0;
        if (reg_wr) begin
            if (hit_mcr) begin
                if (wen) begin
                    mcr_d = reg_wdata;
                end else begin
                    // protected bits hold their value
                    mcr_d = (mcr_q & umcs_pkg::MCR_PROT) | (reg_wdata & ~umcs_pkg::MCR_PROT);
                    denied = |((reg_wdata ^ mcr_q) & umcs_pkg::MCR_PROT);
                end
            end
            if (hit_ier) begin
                if (wen) begin
                    ier_d = reg_wdata;
                end else begin
                    ier_d = (ier_q & umcs_pkg::IER_PROT) | (reg_wdata & ~umcs_pkg::IER_PROT);
                    denied = |((reg_wdata ^ ier_q) & umcs_pkg::IER_PROT);
                end
            end
            if (hit_efr) begin
                efr_d = reg_wdata;
            end
            if (hit_mask) begin
                mask_d = reg_wdata[umcs_pkg::IRQ_W-1:0];
            end
            // threshold registers only reachable while opened
            if (hit_flow) begin
                if (thr_open) begin
                    flow_d = reg_wdata;
                end else begin
                    denied = 1'b1;
                end
            end
            if (hit_trig) begin
                if (thr_open) begin
                    trig_d = reg_wdata;
                end else begin
                    denied = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mcr_q <= umcs_pkg::MCR_RST;
            efr_q <= umcs_pkg::EFR_RST;
            ier_q <= umcs_pkg::IER_RST;
            flow_q <= umcs_pkg::FLOW_RST;
            trig_q <= umcs_pkg::TRIG_RST;
            mask_q <= umcs_pkg::IRQ_MASK_RST;
        end else begin
            mcr_q <= mcr_d;
            efr_q <= efr_d;
            ier_q <= ier_d;
            flow_q <= flow_d;
            trig_q <= trig_d;
            mask_q <= mask_d;
        end
    end

    // modem status sources, ordered cd, ri, dsr, cts
    logic loop_on;
    logic [3:0] src;
    logic [3:0] prev_q;
    logic [3:0] prev_d;
    logic [3:0] delta_q;
    logic [3:0] delta_d;
    logic [3:0] ev;
    logic msr_clr;

    assign loop_on = mcr_q[umcs_pkg::MCR_LOOP];
    assign msr_clr = reg_rd & hit_msr;

    always_comb begin
        if (loop_on) begin
            // control bits stand in for the pins
            src = {mcr_q[umcs_pkg::MCR_IRQ_OP], mcr_q[umcs_pkg::MCR_FRDY],
                   mcr_q[umcs_pkg::MCR_DTR], mcr_q[umcs_pkg::MCR_RTS]};
        end else begin
            // pins are active low, report active high
            src = ~{sif.synced[umcs_pkg::IN_CD], sif.synced[umcs_pkg::IN_RI],
                    sif.synced[umcs_pkg::IN_DSR], sif.synced[umcs_pkg::IN_CTS]};
        end
        ev = src ^ prev_q;
        // ring pin low to high, the reported bit falls
        ev[umcs_pkg::D_RI] = prev_q[umcs_pkg::D_RI] & ~src[umcs_pkg::D_RI];
        prev_d = src;
        // a change in the reading cycle survives the clear
        delta_d = (msr_clr ? 4'h0 : delta_q) | ev;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prev_q <= umcs_pkg::SRC_RST;
            delta_q <= 4'h0;
        end else begin
            prev_q <= prev_d;
            delta_q <= delta_d;
        end
    end

    // interrupt status, cleared by its read, set wins
    logic [umcs_pkg::IRQ_W-1:0] stat_q;
    logic [umcs_pkg::IRQ_W-1:0] stat_d;
    logic [umcs_pkg::IRQ_W-1:0] stat_set;
    logic irq_level;

    always_comb begin
        stat_set = '0;
        stat_set[umcs_pkg::IRQ_MODEM] = ier_q[umcs_pkg::IER_MODEM] & (|delta_q | |ev);
        stat_set[umcs_pkg::IRQ_RING] = ev[umcs_pkg::D_RI];
        stat_set[umcs_pkg::IRQ_DENIED] = denied;
        stat_d = ((reg_rd & hit_stat) ? '0 : stat_q) | stat_set;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    assign irq_level = |(stat_q & mask_q);

    // baud prescaler
    logic [1:0] presc_q;
    logic [1:0] presc_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        if (mcr_q[umcs_pkg::MCR_CLKSEL]) begin
            presc_d = presc_q + 2'h1;
            tick_d = (presc_q == umcs_pkg::PRESC_LAST);
        end else begin
            presc_d = 2'h0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            presc_q <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            presc_q <= presc_d;
            tick_q <= tick_d;
        end
    end

    // registered pins and core outputs
    logic rts_q;
    logic rts_d;
    logic dtr_q;
    logic dtr_d;
    logic op_q;
    logic op_d;
    logic irq_q;
    logic irq_d;
    logic oe_n_q;
    logic oe_n_d;
    logic tx_q;
    logic tx_d;
    logic rx_q;
    logic rx_d;

    always_comb begin
        if (auto_rts_enable) begin
            rts_d = ~auto_rts_assert;
        end else begin
            rts_d = ~mcr_q[umcs_pkg::MCR_RTS];
        end
        dtr_d = ~mcr_q[umcs_pkg::MCR_DTR];
        op_d = ~mcr_q[umcs_pkg::MCR_IRQ_OP];
        oe_n_d = ~mcr_q[umcs_pkg::MCR_IRQ_OP];
        irq_d = irq_level & mcr_q[umcs_pkg::MCR_IRQ_OP];
        if (loop_on) begin
            // line idles high while the transmitter is looped
            tx_d = 1'b1;
            rx_d = core_tx_data;
        end else begin
            tx_d = core_tx_data;
            rx_d = sif.synced[umcs_pkg::IN_RX];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rts_q <= 1'b1;
            dtr_q <= 1'b1;
            op_q <= 1'b1;
            irq_q <= 1'b0;
            oe_n_q <= 1'b1;
            tx_q <= 1'b1;
            rx_q <= 1'b1;
        end else begin
            rts_q <= rts_d;
            dtr_q <= dtr_d;
            op_q <= op_d;
            irq_q <= irq_d;
            oe_n_q <= oe_n_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
        end
    end

    // read data, valid only in the cycle after the strobe
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (hit_mcr) begin
                rdata_d = mcr_q;
            end else if (hit_msr) begin
                rdata_d = {src, delta_q};
            end else if (hit_efr) begin
                rdata_d = efr_q;
            end else if (hit_ier) begin
                rdata_d = ier_q;
            end else if (hit_stat) begin
                rdata_d = {{(8 - umcs_pkg::IRQ_W){1'b0}}, stat_q};
            end else if (hit_mask) begin
                rdata_d = {{(8 - umcs_pkg::IRQ_W){1'b0}}, mask_q};
            end else if (hit_flow && thr_open) begin
                rdata_d = flow_q;
            end else if (hit_trig && thr_open) begin
                rdata_d = trig_q;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign request_send_out = rts_q;
    assign terminal_ready_out = dtr_q;
    assign general_out_pin = op_q;
    assign irq_out_chan_a = irq_q;
    assign irq_out_chan_a_oe_n = oe_n_q;
    assign serial_tx_out = tx_q;
    assign core_rx_data = rx_q;
    assign baud_tick = tick_q;
    assign threshold_access = mcr_q[umcs_pkg::MCR_THR_EN];
    assign xon_any_enable = mcr_q[umcs_pkg::MCR_XON_ANY];
    assign fifo_ready_enable = mcr_q[umcs_pkg::MCR_FRDY];
    assign loopback_active = loop_on;
    assign flow_threshold = flow_q;
    assign trigger_level = trig_q;
endmodule
`default_nettype wire

//--- test/umcs_modem.sv
`timescale 1ns/1ps
`default_nettype none
module umcs_modem (
    // clock and answer delay
    input wire logic clock,
    input wire logic [2:0] lag,
    // lines from the uart, active low
    input wire logic request_send_out,
    input wire logic terminal_ready_out,
    // levels commanded by the bench, active low
    input wire logic carrier_cmd,
    input wire logic ring_cmd,
    // lines towards the uart
    output logic clear_send_in,
    output logic set_ready_in,
    output logic carrier_detect_in,
    output logic ring_indicator_in,
    output logic serial_rx_in
);
    // answer history, idle inactive high
    logic [7:0] rts_h = 8'hff;
    logic [7:0] dtr_h = 8'hff;
    always @(posedge clock) begin
        rts_h <= {rts_h[6:0], request_send_out};
        dtr_h <= {dtr_h[6:0], terminal_ready_out};
    end
    // the data set answers each request lag+1 cycles later
    assign clear_send_in = rts_h[lag];
    assign set_ready_in = dtr_h[lag];
    assign carrier_detect_in = carrier_cmd;
    assign ring_indicator_in = ring_cmd;
    // serial line rests at mark
    assign serial_rx_in = 1'b1;
endmodule
`default_nettype wire

//--- test/umcs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module umcs_chk (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // modem pins
    input wire logic clear_send_in,
    input wire logic set_ready_in,
    input wire logic carrier_detect_in,
    input wire logic ring_indicator_in,
    input wire logic request_send_out,
    input wire logic terminal_ready_out,
    input wire logic general_out_pin,
    input wire logic irq_out_chan_a,
    input wire logic irq_out_chan_a_oe_n,
    // serial and core side
    input wire logic serial_tx_out,
    input wire logic core_tx_data,
    input wire logic core_rx_data,
    input wire logic auto_rts_enable,
    input wire logic auto_rts_assert,
    input wire logic baud_tick,
    input wire logic threshold_access,
    input wire logic xon_any_enable,
    input wire logic fifo_ready_enable,
    input wire logic loopback_active
);
    logic [7:0] ctl_q, ctl_d;
    logic wen_q, wen_d;
    logic [3:0] pin_q, pins, src;
    logic [2:0] quiet_q, quiet_d;
    assign pins = {carrier_detect_in, ring_indicator_in, set_ready_in, clear_send_in};
    assign src = ctl_q[4] ? {ctl_q[3], ctl_q[2], ctl_q[0], ctl_q[1]} : ~pins;
    always_comb begin
        ctl_d = ctl_q;
        wen_d = wen_q;
        if (reg_wr && reg_addr == umcs_pkg::EFR_OFS) wen_d = reg_wdata[4];
        if (reg_wr && reg_addr == umcs_pkg::MCR_OFS) ctl_d = wen_q ? reg_wdata : {ctl_q[7:5], reg_wdata[4:0]};
        quiet_d = (ctl_d != ctl_q || pins != pin_q) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl_q <= 8'h00;
            wen_q <= 1'b0;
            pin_q <= 4'hf;
            quiet_q <= 3'h0;
        end else begin
            ctl_q <= ctl_d;
            wen_q <= wen_d;
            pin_q <= pins;
            quiet_q <= quiet_d;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_quarter;
        !baud_tick [*3] ##1 baud_tick;
    endsequence
    sequence s_status_read;
        reg_rd && reg_addr == umcs_pkg::MSR_OFS && quiet_q == 3'h7;
    endsequence
    chk_dtr_pin: assert property (terminal_ready_out == !$past(ctl_q[0]))
        else $error("terminal ready pin wrong");
    chk_rts_pin: assert property (request_send_out == ($past(auto_rts_enable) ? !$past(auto_rts_assert) : !$past(ctl_q[1])))
        else $error("request send pin wrong");
    chk_op_oe: assert property (general_out_pin == !$past(ctl_q[3]) && irq_out_chan_a_oe_n == !$past(ctl_q[3]))
        else $error("general pin or interrupt enable wrong");
    chk_irq_quiet: assert property (irq_out_chan_a_oe_n |-> !irq_out_chan_a)
        else $error("interrupt high while released");
    chk_mode_bits: assert property ({loopback_active, xon_any_enable, threshold_access, fifo_ready_enable} == {ctl_q[4], ctl_q[5], ctl_q[6], ctl_q[2]})
        else $error("mode outputs wrong");
    chk_protect_hold: assert property (reg_wr && reg_addr == umcs_pkg::MCR_OFS && !wen_q |=> $stable(threshold_access) && $stable(xon_any_enable))
        else $error("protected bits changed");
    chk_div_one: assert property (!$past(sys_rst) && !ctl_q[7] |=> baud_tick)
        else $error("tick missing in divide by one");
    chk_div_four: assert property (baud_tick && ctl_q[7] && $past(ctl_q[7]) |=> s_quarter)
        else $error("tick cadence wrong in divide by four");
    chk_tx_path: assert property (serial_tx_out == ($past(ctl_q[4]) ? 1'b1 : $past(core_tx_data)))
        else $error("serial output wrong");
    chk_rx_loop: assert property ($past(ctl_q[4]) |-> core_rx_data == $past(core_tx_data))
        else $error("loopback receive wrong");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_status_src: assert property (s_status_read |=> reg_rdata[7:4] == $past(src))
        else $error("status levels wrong");
endmodule
bind umcs_top umcs_chk u_chk (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .clear_send_in, .set_ready_in, .carrier_detect_in, .ring_indicator_in, .request_send_out,
    .terminal_ready_out, .general_out_pin, .irq_out_chan_a, .irq_out_chan_a_oe_n, .serial_tx_out,
    .core_tx_data, .core_rx_data, .auto_rts_enable, .auto_rts_assert, .baud_tick, .threshold_access,
    .xon_any_enable, .fifo_ready_enable, .loopback_active);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] A_CTL = umcs_pkg::MCR_OFS;
    localparam logic [7:0] A_STA = umcs_pkg::MSR_OFS;
    localparam logic [7:0] A_IST = umcs_pkg::IRQ_STAT_OFS;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic core_tx_data = 1'b1;
    logic auto_rts_enable = 1'b0;
    logic auto_rts_assert = 1'b0;
    logic carrier_cmd = 1'b1;
    logic ring_cmd = 1'b1;
    logic [2:0] lag = 3'h0;
    logic [7:0] reg_rdata, flow_threshold, trigger_level, rd_val;
    logic clear_send_in, set_ready_in, carrier_detect_in, ring_indicator_in, serial_rx_in, irq;
    logic request_send_out, terminal_ready_out, general_out_pin, irq_out_chan_a_oe_n, serial_tx_out;
    logic core_rx_data, baud_tick, threshold_access, xon_any_enable, fifo_ready_enable, loopback_active;
    int mismatches = 0;
    int tests_run = 0;
    int ticks;
    // control value written, expected {rts, dtr, op, oe_n, loop, thr, xon, fifo}
    logic [15:0] rows [9] = '{16'h00f0, 16'h01b0, 16'h0270, 16'h08c0, 16'h10f8, 16'h40f4, 16'h20f2,
        16'h04f1, 16'h0b00};

    umcs_top DUT (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clear_send_in,
        .set_ready_in, .carrier_detect_in, .ring_indicator_in, .request_send_out, .terminal_ready_out,
        .general_out_pin, .irq_out_chan_a(irq), .irq_out_chan_a_oe_n, .serial_rx_in, .serial_tx_out,
        .core_tx_data, .core_rx_data, .auto_rts_enable, .auto_rts_assert, .baud_tick, .threshold_access,
        .xon_any_enable, .fifo_ready_enable, .loopback_active, .flow_threshold, .trigger_level);
    umcs_modem u_modem (.clock, .lag, .request_send_out, .terminal_ready_out, .carrier_cmd, .ring_cmd,
        .clear_send_in, .set_ready_in, .carrier_detect_in, .ring_indicator_in, .serial_rx_in);

    always #5 clock = ~clock;
    always @(posedge clock) core_tx_data <= sys_rst | ~core_tx_data;

    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        check(what, rd_val, exp);
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        rchk("ctl reset", A_CTL, 8'h00);
        rchk("status reset", A_STA, 8'h00);
        rchk("unmapped", 8'hfc, 8'h00);
        wr(umcs_pkg::EFR_OFS, 8'h10);
        foreach (rows[i]) begin
            wr(A_CTL, rows[i][15:8]);
            cyc(2);
            check("pins", {request_send_out, terminal_ready_out, general_out_pin, irq_out_chan_a_oe_n,
                loopback_active, threshold_access, xon_any_enable, fifo_ready_enable}, rows[i][7:0]);
            rchk("ctl readback", A_CTL, rows[i][15:8]);
        end
        auto_rts_enable <= 1'b1;
        cyc(2);
        check("auto rts", {7'h00, request_send_out}, 8'h01);
        auto_rts_enable <= 1'b0;
        wr(A_CTL, 8'h00);
        rd(A_IST);
        wr(umcs_pkg::EFR_OFS, 8'h00);
        wr(A_CTL, 8'he0);
        rchk("protected", A_CTL, 8'h00);
        rd(A_IST);
        check("refused flag", rd_val & 8'h04, 8'h04);
        wr(umcs_pkg::FLOW_THR_OFS, 8'h5a);
        rchk("thr closed", umcs_pkg::FLOW_THR_OFS, 8'h00);
        wr(umcs_pkg::EFR_OFS, 8'h10);
        wr(A_CTL, 8'h40);
        wr(umcs_pkg::FLOW_THR_OFS, 8'h5a);
        rchk("thr open", umcs_pkg::FLOW_THR_OFS, 8'h5a);
        check("thr out", flow_threshold, 8'h5a);
        wr(umcs_pkg::TRIG_LVL_OFS, 8'h3c);
        rchk("trig open", umcs_pkg::TRIG_LVL_OFS, 8'h3c);
        check("trig out", trigger_level, 8'h3c);
        wr(A_CTL, 8'h00);
        rd(A_STA);
        carrier_cmd <= 1'b0;
        cyc(10);
        rchk("cd fall", A_STA, 8'h88);
        rchk("cd clear", A_STA, 8'h80);
        ring_cmd <= 1'b0;
        cyc(10);
        rchk("ri fall", A_STA, 8'hc0);
        ring_cmd <= 1'b1;
        cyc(10);
        rchk("ri rise", A_STA, 8'h84);
        lag <= 3'h7;
        wr(A_CTL, 8'h01);
        cyc(14);
        rchk("dsr", A_STA, 8'ha2);
        lag <= 3'h0;
        wr(A_CTL, 8'h03);
        cyc(8);
        rchk("cts", A_STA, 8'hb1);
        wr(umcs_pkg::IER_OFS, 8'h08);
        wr(A_CTL, 8'h0b);
        rd(A_STA);
        rd(A_IST);
        cyc(3);
        check("irq idle", {7'h00, irq}, 8'h00);
        carrier_cmd <= 1'b1;
        cyc(8);
        check("irq raised", {7'h00, irq}, 8'h01);
        wr(umcs_pkg::IRQ_MASK_OFS, 8'h00);
        cyc(2);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(umcs_pkg::IRQ_MASK_OFS, 8'h07);
        cyc(2);
        check("irq unmasked", {7'h00, irq}, 8'h01);
        rd(A_STA);
        rd(A_IST);
        check("irq status", rd_val & 8'h01, 8'h01);
        cyc(2);
        check("irq cleared", {7'h00, irq}, 8'h00);
        wr(A_CTL, 8'h10);
        cyc(6);
        rd(A_STA);
        wr(A_CTL, 8'h1d);
        cyc(10);
        rchk("loop levels", A_STA, 8'hea);
        wr(A_CTL, 8'h19);
        cyc(10);
        rchk("loop ring", A_STA, 8'ha4);
        wr(A_CTL, 8'h80);
        cyc(4);
        ticks = 0;
        repeat (40) begin
            cyc(1);
            ticks += baud_tick;
        end
        check("ticks", ticks[7:0], 8'h0a);
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        rchk("ctl after reset", A_CTL, 8'h00);
        check("rx idle", {7'h00, core_rx_data}, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
